// *** src/dmx_pkg.sv ***
package dmx_pkg;
    // ----------------------------------------
    // Register map and subbank layout
    // ----------------------------------------
    localparam logic [7:0] ADDR_PREC = 8'h54;
    localparam logic [7:0] ADDR_PTR = 8'h55;
    localparam logic [7:0] ADDR_DATA_INC = 8'h56;
    localparam logic [7:0] ADDR_DATA_PLAIN = 8'h57;
    localparam int NUM_CH = 6;
    localparam int CH_STRIDE = 5;
    localparam int SUB_SRC = 0;
    localparam int SUB_DST = 1;
    localparam int SUB_CTR = 2;
    localparam int SUB_SFC = 3;
    localparam int SUB_MCR = 4;
    localparam int SUB_IDX0 = 32;
    localparam int SUB_IDX1 = 33;
    localparam int SUB_FRI0 = 34;
    localparam int SUB_FRI1 = 35;
    localparam int SUB_WORDS = 36;
    localparam logic [15:0] SUB_LIMIT = 16'h0024;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PREC_EN_LSB = 0;
    localparam int PREC_SEL_LSB = 6;
    localparam int MCR_IEN = 14;
    localparam int MCR_IMODE = 13;
    localparam int MCR_ABU = 12;
    localparam int MCR_SOURCE_INDEX_SELECT_LSB = 8;
    localparam int MCR_DEST_INDEX_SELECT_LSB = 2;
    localparam int SFC_SYNC_LSB = 12;
    localparam int SFC_FRM_LSB = 0;

    // ----------------------------------------
    // Encodings and reset values
    // ----------------------------------------
    localparam logic [2:0] IDX_NONE = 3'h0;
    localparam logic [2:0] IDX_INC = 3'h1;
    localparam logic [2:0] IDX_DEC = 3'h2;
    localparam logic [2:0] IDX_REG0 = 3'h3;
    localparam logic [2:0] IDX_REG1 = 3'h4;
    localparam logic [3:0] SYNC_NONE = 4'h0;
    localparam logic [3:0] SYNC_SP0_RX = 4'h1;
    localparam logic [3:0] SYNC_SP0_TX = 4'h2;
    localparam logic [3:0] SYNC_SP1_RX = 4'h5;
    localparam logic [3:0] SYNC_SP1_TX = 4'h6;
    localparam logic [3:0] SYNC_TMR0 = 4'hd;
    localparam logic [3:0] SYNC_EXT3 = 4'he;
    localparam logic [3:0] SYNC_TMR1 = 4'hf;
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_CH23 = 2'h1;
    localparam logic [1:0] SEL_CH0123 = 2'h2;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] ONE_WORD = 16'h0001;

    // Whole state of the block
    typedef struct packed {
        logic [15:0] prec;
        logic [15:0] ptr;
        logic [SUB_WORDS-1:0][15:0] sub;
        logic [NUM_CH-1:0][15:0] size;
        logic [15:0] rdata;
        logic [NUM_CH-1:0] req;
        logic [5:0] irq;
    } dmx_state_t;
endpackage : dmx_pkg

// *** src/dmx_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Mode word fields pick element/frame index register for source and destination.
// - Non-last element of a frame adds the selected element index.
// - Last element of a frame adds the selected frame index instead.
// - Interrupt enable low means the channel never interrupts.
// - Autobuffer: full only with mode 0; half and full with mode 1.
// - Multi-frame: mode 0 at block end only; mode 1 each frame end.
// - Four-bit sync field picks pacing event; zero means unsynchronized.
// - Codes 1,2 serial port 0 rx/tx; 5,6 serial port 1 rx/tx.
// - Codes d, e, f select timer 0, external 3, timer 1.
// - Channels 0-3 share processor lines 6, 7, 10, 11.
// - After reset the select field is 00, other sources own lines.
// - Select 01 routes channels 2,3; 10 routes channels 0 to 3.
// - Control at 54h, pointer 55h, autoincrement data 56h, plain 57h.
// - Autoincrement port advances the pointer; plain port leaves it.
// - Element count drops per element, frame count at frame end.
module dmx_ctrl (
    input wire logic mclk_in, // Device clock
    input wire logic nrst_in, // Synchronous reset, low
    input wire logic [7:0] addr_in, // Data address
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic [15:0] wdata_in, // Write data
    output logic [15:0] rdata_out, // Read data, next cycle
    input wire logic [5:0] xfer_done_in, // Element moved, per channel
    input wire logic [3:0] serial_ev_in, // Sp0 rx, sp0 tx, sp1 rx, sp1 tx
    input wire logic timer_zero_ev_in, // Timer 0 event
    input wire logic ext_three_ev_in, // External interrupt 3
    input wire logic timer_one_irq_in, // Timer 1 interrupt
    input wire logic serial_one_receive_irq_in, // Serial 1 rx interrupt
    input wire logic serial_one_transmit_irq_in, // Serial 1 tx interrupt
    input wire logic reserved_irq_in, // Reserved line 6 source
    output logic [5:0] xfer_req_out, // Transfer request per channel
    output logic [5:0] irq_out // Lines 6, 7, 10, 11, ch4, ch5
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Sync event decode
    function automatic logic sync_hit(input logic [3:0] code,
                                      input logic [3:0] sp,
                                      input logic t0, e3, t1);
        unique case (code)
            dmx_pkg::SYNC_NONE: sync_hit = 1'b1;
            dmx_pkg::SYNC_SP0_RX: sync_hit = sp[0];
            dmx_pkg::SYNC_SP0_TX: sync_hit = sp[1];
            dmx_pkg::SYNC_SP1_RX: sync_hit = sp[2];
            dmx_pkg::SYNC_SP1_TX: sync_hit = sp[3];
            dmx_pkg::SYNC_TMR0: sync_hit = t0;
            dmx_pkg::SYNC_EXT3: sync_hit = e3;
            dmx_pkg::SYNC_TMR1: sync_hit = t1;
            default: sync_hit = 1'b0; // Reserved codes
        endcase
    endfunction : sync_hit

    // Address step for one index select field
    function automatic logic [15:0] step(input logic [2:0] sel,
                                         input logic last,
                                         input logic [15:0] i0, i1, f0, f1);
        unique case (sel)
            dmx_pkg::IDX_INC: step = dmx_pkg::ONE_WORD;
            dmx_pkg::IDX_DEC: step = -dmx_pkg::ONE_WORD;
            dmx_pkg::IDX_REG0: step = last ? f0 : i0;
            dmx_pkg::IDX_REG1: step = last ? f1 : i1;
            default: step = dmx_pkg::RESET_WORD;
        endcase
    endfunction : step

    // ----------------------------------------
    // State
    // ----------------------------------------
    dmx_pkg::dmx_state_t st;
    dmx_pkg::dmx_state_t next_st;
    logic [5:0] ev;
    logic sub_acc;
    logic sub_ok;
    logic [5:0] sub_idx;
    logic [1:0] sel;

    assign sub_acc = (addr_in == dmx_pkg::ADDR_DATA_INC)
                   || (addr_in == dmx_pkg::ADDR_DATA_PLAIN);
    assign sub_ok = st.ptr < dmx_pkg::SUB_LIMIT;
    assign sub_idx = st.ptr[5:0];
    assign sel = st.prec[dmx_pkg::PREC_SEL_LSB +: 2];

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [15:0] ctr;
        logic [15:0] sfc;
        logic [15:0] mcr;
        logic last;
        logic fin;
        int b;
        ctr = '0;
        sfc = '0;
        mcr = '0;
        last = 1'b0;
        fin = 1'b0;
        b = 0;
        next_st = st;
        ev = '0;
        // Channel engines
        for (int c = 0; c < dmx_pkg::NUM_CH; c++) begin
            b = c * dmx_pkg::CH_STRIDE;
            ctr = st.sub[b + dmx_pkg::SUB_CTR];
            sfc = st.sub[b + dmx_pkg::SUB_SFC];
            mcr = st.sub[b + dmx_pkg::SUB_MCR];
            next_st.req[c] = st.prec[dmx_pkg::PREC_EN_LSB + c]
                && sync_hit(sfc[dmx_pkg::SFC_SYNC_LSB +: 4], serial_ev_in,
                            timer_zero_ev_in, ext_three_ev_in,
                            timer_one_irq_in);
            if (st.prec[dmx_pkg::PREC_EN_LSB + c] && xfer_done_in[c]) begin
                last = (ctr == dmx_pkg::RESET_WORD);
                fin = 1'b0;
                next_st.sub[b + dmx_pkg::SUB_SRC] = st.sub[b + dmx_pkg::SUB_SRC]
                    + step(mcr[dmx_pkg::MCR_SOURCE_INDEX_SELECT_LSB +: 3], last,
                           st.sub[dmx_pkg::SUB_IDX0], st.sub[dmx_pkg::SUB_IDX1],
                           st.sub[dmx_pkg::SUB_FRI0],
                           st.sub[dmx_pkg::SUB_FRI1]);
                next_st.sub[b + dmx_pkg::SUB_DST] = st.sub[b + dmx_pkg::SUB_DST]
                    + step(mcr[dmx_pkg::MCR_DEST_INDEX_SELECT_LSB +: 3], last,
                           st.sub[dmx_pkg::SUB_IDX0], st.sub[dmx_pkg::SUB_IDX1],
                           st.sub[dmx_pkg::SUB_FRI0],
                           st.sub[dmx_pkg::SUB_FRI1]);
                if (!last) begin
                    next_st.sub[b + dmx_pkg::SUB_CTR] = ctr - dmx_pkg::ONE_WORD;
                    // Half buffer point
                    fin = mcr[dmx_pkg::MCR_ABU] && mcr[dmx_pkg::MCR_IMODE]
                        && (ctr - dmx_pkg::ONE_WORD == (st.size[c] >> 1));
                end else if (mcr[dmx_pkg::MCR_ABU]) begin
                    next_st.sub[b + dmx_pkg::SUB_CTR] = st.size[c];
                    fin = 1'b1; // Full buffer
                end else if (sfc[7:0] == 8'h00) begin
                    next_st.prec[dmx_pkg::PREC_EN_LSB + c] = 1'b0;
                    fin = 1'b1; // Block end
                end else begin
                    next_st.sub[b + dmx_pkg::SUB_SFC] = {sfc[15:8],
                        sfc[7:0] - 8'h01};
                    next_st.sub[b + dmx_pkg::SUB_CTR] = st.size[c];
                    fin = mcr[dmx_pkg::MCR_IMODE]; // Frame end
                end
                ev[c] = fin && mcr[dmx_pkg::MCR_IEN];
            end
        end
        // Interrupt routing, one pulse per condition
        next_st.irq[0] = (sel == dmx_pkg::SEL_CH0123) ? ev[0]
                       : reserved_irq_in;
        next_st.irq[1] = (sel == dmx_pkg::SEL_CH0123) ? ev[1]
                       : timer_one_irq_in;
        next_st.irq[2] = (sel == dmx_pkg::SEL_CH23 || sel ==
            dmx_pkg::SEL_CH0123) ? ev[2] : serial_one_receive_irq_in;
        next_st.irq[3] = (sel == dmx_pkg::SEL_CH23 || sel ==
            dmx_pkg::SEL_CH0123) ? ev[3] : serial_one_transmit_irq_in;
        next_st.irq[4] = ev[4];
        next_st.irq[5] = ev[5];
        // Register reads
        unique case (addr_in)
            dmx_pkg::ADDR_PREC: next_st.rdata = st.prec;
            dmx_pkg::ADDR_PTR: next_st.rdata = st.ptr;
            dmx_pkg::ADDR_DATA_INC, dmx_pkg::ADDR_DATA_PLAIN:
                next_st.rdata = sub_ok ? st.sub[sub_idx] : dmx_pkg::RESET_WORD;
            default: next_st.rdata = dmx_pkg::RESET_WORD;
        endcase
        if (!rd_in) begin
            next_st.rdata = st.rdata;
        end
        // Register writes, software wins over engine updates
        if (wr_in && addr_in == dmx_pkg::ADDR_PREC) begin
            next_st.prec = wdata_in;
            for (int c = 0; c < dmx_pkg::NUM_CH; c++) begin
                if (wdata_in[c] && !st.prec[c]) begin
                    next_st.size[c] = st.sub[c * dmx_pkg::CH_STRIDE
                                             + dmx_pkg::SUB_CTR];
                end
            end
        end
        if (wr_in && sub_acc && sub_ok) begin
            next_st.sub[sub_idx] = wdata_in;
        end
        if (wr_in && addr_in == dmx_pkg::ADDR_PTR) begin
            next_st.ptr = wdata_in;
        end else if ((wr_in || rd_in)
                     && addr_in == dmx_pkg::ADDR_DATA_INC) begin
            next_st.ptr = st.ptr + dmx_pkg::ONE_WORD;
        end
    end

    // State register
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            st <= '0; // Select field reads 00
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign rdata_out = st.rdata;
    assign xfer_req_out = st.req;
    assign irq_out = st.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    logic cpu_sub;
    assign cpu_sub = wr_in && sub_acc;

    elem_index_a: assert property (st.prec[0] && xfer_done_in[0] && !cpu_sub
        && st.sub[dmx_pkg::SUB_CTR] != 16'h0000
        && st.sub[dmx_pkg::SUB_MCR][10:8] == dmx_pkg::IDX_REG0
        |=> st.sub[dmx_pkg::SUB_SRC] == $past(st.sub[dmx_pkg::SUB_SRC])
            + $past(st.sub[dmx_pkg::SUB_IDX0]))
        else $error("element index not applied");
    frame_index_a: assert property (st.prec[0] && xfer_done_in[0] && !cpu_sub
        && st.sub[dmx_pkg::SUB_CTR] == 16'h0000
        && st.sub[dmx_pkg::SUB_MCR][10:8] == dmx_pkg::IDX_REG0
        |=> st.sub[dmx_pkg::SUB_SRC] == $past(st.sub[dmx_pkg::SUB_SRC])
            + $past(st.sub[dmx_pkg::SUB_FRI0]))
        else $error("frame index not applied");
    irq_off_a: assert property (!st.sub[24][14] && !cpu_sub
        |=> !irq_out[4])
        else $error("disabled channel raised interrupt");
    count_dec_a: assert property (st.prec[1] && xfer_done_in[1] && !cpu_sub
        && st.sub[7] != 16'h0000
        |=> st.sub[7] == $past(st.sub[7]) - 16'h0001)
        else $error("element count not decremented");
    sync_sel_a: assert property (st.prec[0] && serial_ev_in[0]
        && st.sub[3][15:12] == dmx_pkg::SYNC_SP0_RX
        |=> xfer_req_out[0])
        else $error("sync event lost");
    ptr_inc_a: assert property (rd_in && addr_in == dmx_pkg::ADDR_DATA_INC
        |=> st.ptr == $past(st.ptr) + 16'h0001)
        else $error("pointer not advanced");
    ptr_hold_a: assert property (rd_in && addr_in == dmx_pkg::ADDR_DATA_PLAIN
        |=> $stable(st.ptr))
        else $error("pointer moved on plain port");
    route_sel_a: assert property (sel == dmx_pkg::SEL_CH0123 && ev[1]
        |=> irq_out[1])
        else $error("channel 1 not routed");
    reset_sel_a: assert property (@(posedge mclk_in) disable iff (1'b0)
        !nrst_in
        |=> st.prec[7:6] == dmx_pkg::SEL_DEFAULT)
        else $error("select field not cleared");
endmodule : dmx_ctrl

// *** testbench/dmx_periph.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral events and processor flags
// ----------------------------------------
module dmx_periph (
    input wire logic mclk_in, // Device clock
    input wire logic [6:0] ev_in, // Sync event levels
    input wire logic [3:0] src_in, // Shared line sources
    input wire logic [5:0] irq_in, // Routed requests
    output logic [3:0] serial_ev_out, // Serial events
    output logic timer_zero_out, // Timer 0 event
    output logic ext_three_out, // External 3 event
    output logic [3:0] line_src_out, // Reserved, timer 1, rx, tx
    output int flag_cnt_out [6] // Flag sets per line
);
    // Event fan-out, timer 1 also drives its shared line
    assign serial_ev_out = ev_in[3:0];
    assign timer_zero_out = ev_in[4];
    assign ext_three_out = ev_in[5];
    assign line_src_out = {src_in[3:2], src_in[1] | ev_in[6], src_in[0]};
    // One flag set per request cycle
    always @(posedge mclk_in) begin
        for (int i = 0; i < 6; i++) begin
            flag_cnt_out[i] <= flag_cnt_out[i] + int'(irq_in[i]);
        end
    end
endmodule : dmx_periph

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Stimulus, tasks and checks
    // ----------------------------------------
    localparam logic [7:0] A_PR = dmx_pkg::ADDR_PREC;
    localparam logic [7:0] A_PT = dmx_pkg::ADDR_PTR;
    localparam logic [7:0] A_IN = dmx_pkg::ADDR_DATA_INC;
    localparam logic [7:0] A_PL = dmx_pkg::ADDR_DATA_PLAIN;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [5:0] done = 6'h00;
    logic [6:0] ev = 7'h00;
    logic [3:0] src = 4'h0;
    logic [5:0] req, irq;
    logic [3:0] sev, lsrc;
    logic t0, e3;
    int flags [6];
    int snap [4];
    int n_fail = 0;
    int n_checks = 0;
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'hd, 4'he,
        4'hf, 4'h3};
    int evb [9] = '{7, 0, 1, 2, 3, 4, 5, 6, 7};
    logic [3:0] smask [4] = '{4'hf, 4'h3, 4'h0, 4'hf};

    // Clock
    always #2 mclk_in = ~mclk_in;

    dmx_ctrl uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata),
        .xfer_done_in(done), .serial_ev_in(sev), .timer_zero_ev_in(t0),
        .ext_three_ev_in(e3), .timer_one_irq_in(lsrc[1]),
        .serial_one_receive_irq_in(lsrc[2]),
        .serial_one_transmit_irq_in(lsrc[3]), .reserved_irq_in(lsrc[0]),
        .xfer_req_out(req), .irq_out(irq));
    dmx_periph peer (.mclk_in(mclk_in), .ev_in(ev), .src_in(src),
        .irq_in(irq), .serial_ev_out(sev), .timer_zero_out(t0),
        .ext_three_out(e3), .line_src_out(lsrc), .flag_cnt_out(flags));

    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : step

    // One register access, strobe held for one edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        step(1);
        wr = w;
        rd = ~w;
        addr = a;
        wdata = d;
        step(1);
        wr = 1'b0;
        rd = 1'b0;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(rdata, exp);
    endtask : rdchk

    task automatic sw(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, A_PT, {8'h00, a});
        bus(1'b1, A_PL, d);
    endtask : sw

    task automatic sr(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b1, A_PT, {8'h00, a});
        rdchk(A_PL, exp);
    endtask : sr

    task automatic pulse(input int ch);
        done[ch] = 1'b1;
        step(1);
        done = 6'h00;
        step(3);
    endtask : pulse

    // Program a channel through the autoincrement port, then enable it
    task automatic setup(input int ch, input logic [15:0] ctr, sfc, mode,
                         input logic [1:0] sel);
        bus(1'b1, A_PR, {8'h00, sel, 6'h00});
        bus(1'b1, A_PT, 16'(ch * 5));
        bus(1'b1, A_IN, 16'h1000);
        bus(1'b1, A_IN, 16'h2000);
        bus(1'b1, A_IN, ctr);
        bus(1'b1, A_IN, sfc);
        bus(1'b1, A_IN, mode);
        bus(1'b1, A_PR, {8'h00, sel, 6'(1 << ch)});
    endtask : setup

    task automatic irqrun(input int ch, input logic [15:0] ctr, sfc, mode,
                          input logic [1:0] sel, input int n, b,
                          input logic [15:0] exp);
        int k;
        setup(ch, ctr, sfc, mode, sel);
        k = flags[b];
        repeat (n) pulse(ch);
        chk(16'(flags[b] - k), exp);
    endtask : irqrun

    // Hang guard
    initial begin
        step(50000);
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial begin
        step(4);
        nrst_in = 1'b1;
        rdchk(A_PR, 16'h0000);
        bus(1'b1, A_PT, 16'h001e);
        bus(1'b1, A_IN, 16'haaaa);
        rdchk(A_PT, 16'h001f);
        bus(1'b1, A_PL, 16'h5555);
        rdchk(A_PT, 16'h001f);
        bus(1'b1, A_PT, 16'h001e);
        rdchk(A_IN, 16'haaaa);
        rdchk(A_PL, 16'h5555);
        rdchk(8'h58, 16'h0000);
        sw(8'h20, 16'h0010);
        sw(8'h21, 16'h0020);
        sw(8'h22, 16'h0100);
        sw(8'h23, 16'h0200);
        setup(5, 16'h0001, 16'h0000, 16'h0310, 2'h0);
        pulse(5);
        sr(8'd25, 16'h1010);
        sr(8'd26, 16'h2020);
        sr(8'd27, 16'h0000);
        pulse(5);
        sr(8'd25, 16'h1110);
        sr(8'd26, 16'h2220);
        rdchk(A_PR, 16'h0000);
        setup(5, 16'h0001, 16'h0000, 16'h0108, 2'h0);
        pulse(5);
        sr(8'd25, 16'h1001);
        sr(8'd26, 16'h1fff);
        irqrun(5, 16'h0000, 16'h0000, 16'h4000, 2'h0, 1, 5, 1);
        irqrun(4, 16'h0000, 16'h0000, 16'h2000, 2'h0, 1, 4, 0);
        irqrun(4, 16'h0000, 16'h0001, 16'h4000, 2'h0, 2, 4, 1);
        irqrun(4, 16'h0000, 16'h0001, 16'h6000, 2'h0, 2, 4, 2);
        irqrun(4, 16'h0003, 16'h0000, 16'h5000, 2'h0, 4, 4, 1);
        irqrun(4, 16'h0003, 16'h0000, 16'h7000, 2'h0, 4, 4, 2);
        irqrun(0, 16'h0000, 16'h0000, 16'h4000, 2'h2, 1, 0, 1);
        irqrun(1, 16'h0000, 16'h0000, 16'h4000, 2'h2, 1, 1, 1);
        irqrun(2, 16'h0000, 16'h0000, 16'h4000, 2'h1, 1, 2, 1);
        irqrun(3, 16'h0000, 16'h0000, 16'h4000, 2'h1, 1, 3, 1);
        irqrun(1, 16'h0000, 16'h0000, 16'h4000, 2'h1, 1, 1, 0);
        irqrun(0, 16'h0000, 16'h0000, 16'h4000, 2'h0, 1, 0, 0);
        // Shared line sources under each select value
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, A_PR, {8'h00, 2'(s), 6'h00});
            for (int k = 0; k < 4; k++) snap[k] = flags[k];
            src = 4'hf;
            step(1);
            src = 4'h0;
            step(3);
            for (int k = 0; k < 4; k++) begin
                chk(16'(flags[k] - snap[k]), {15'h0, smask[s][k]});
            end
        end
        // Sync event decoding on channel 0
        setup(0, 16'h00ff, 16'h0000, 16'h0000, 2'h0);
        for (int i = 0; i < 9; i++) begin
            sw(8'h03, {codes[i], 12'h000});
            ev = 7'(1 << evb[i]);
            step(2);
            chk({15'h0, req[0]}, {15'h0, codes[i] != 4'h3});
            ev = ~7'(1 << evb[i]);
            step(2);
            chk({15'h0, req[0]}, {15'h0, codes[i] == 4'h0});
            ev = 7'h00;
        end
        print_verdict();
    end
endmodule : tb
